//--- rtl/svi_entry.sv
// Interrupt entry and return sequencer with pending, enable and global
// enable registers, for an 8-bit core with one shared interrupt vector.
// Assumes the core holds pc, flags and stack pointer steady while busy is
// high, and that memory answers a read in the cycle after the request.
//
// How it works
// - Every source uses one vector at program addresses 0000H and 0001H.
// - Bit 3 of system mode register at DFH is the software-writable enable.
// - Global enable 0 disables like the disable instruction; 1 enables.
// - Service needs global enable set and the source's own enable set.
// - A pending request is taken only at the end of an instruction.
// - Taking a request pulses acknowledge, then starts the entry cycle.
// - Entry first clears the global enable bit.
// - Entry pushes pc low, pc high, then the flags.
// - Handler high byte read from 0000H, low from 0001H, then branch.
// - Return instruction restores pc and flags and sets global enable.
// - A source requests by setting its own pending bit.
// - Pending bits survive acknowledge; software clears them before return.
// - No priority hardware; software polls pending bits for order.
// - Fourteen sources: timers, serial, watch timer, port 0, 1, 3 lines.
// - Writing 0 to a pending bit clears it; 1 leaves it.
// - Watch timer pending is bit 3 of pending register two.
//
// Added by the designer: the register addresses and strobed register access.
module svi_entry
    import svi_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    // Peripheral event pulses
    input  wire logic [SVI_NUM_SRC-1:0] src_event,
    // Core side
    input  wire logic                   instr_end,
    input  wire logic                   enable_interrupts_instr,
    input  wire logic                   disable_interrupts_instr,
    input  wire logic                   interrupt_return_instr,
    input  wire logic [15:0]            cpu_pc,
    input  wire logic [7:0]             cpu_flags,
    input  wire logic [7:0]             cpu_sp,
    output logic                        irq_req,
    output logic                        cpu_ack,
    output logic                        busy,
    output svi_load_t                   cpu_load,
    output logic                        global_enable,
    // Memory port for stack and vector
    output svi_mem_t                    mem,
    input  wire logic [7:0]             mem_rdata,
    // Interrupt to the system
    output logic                        irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    svi_state_t st_ff;
    svi_state_t nxt_st;

    logic [SVI_NUM_SRC-1:0] clr_mask;
    logic [1:0]             stat_set;
    logic                   wr_sys;

    // Unmasked request level towards the core.
    assign irq_req = |(st_ff.pend & st_ff.ena);

    always_comb begin
        clr_mask = '0;
        stat_set = SVI_STAT_RST;
        wr_sys   = reg_wr && (reg_addr == SVI_ADDR_SYS_MODE);
        nxt_st   = st_ff;

        nxt_st.ack             = 1'b0;
        nxt_st.mem             = '0;
        nxt_st.load.pc_load    = 1'b0;
        nxt_st.load.flags_load = 1'b0;
        nxt_st.load.sp_load    = 1'b0;

        // ************************************************************
        // Register writes
        // ************************************************************
        if (wr_sys) begin
            nxt_st.sys_mode = reg_wdata;
        end
        if (enable_interrupts_instr) begin
            nxt_st.sys_mode[SVI_GIE_BIT] = 1'b1;
        end
        if (disable_interrupts_instr) begin
            nxt_st.sys_mode[SVI_GIE_BIT] = 1'b0;
        end
        if (reg_wr && reg_addr == SVI_ADDR_PEND_ONE) begin
            clr_mask[SVI_PEND_ONE_W-1:0] = ~reg_wdata;
        end
        if (reg_wr && reg_addr == SVI_ADDR_PEND_TWO) begin
            clr_mask[SVI_NUM_SRC-1:SVI_PEND_ONE_W] =
                ~reg_wdata[SVI_PEND_TWO_W-1:0];
        end
        if (reg_wr && reg_addr == SVI_ADDR_ENA_ONE) begin
            nxt_st.ena[SVI_PEND_ONE_W-1:0] = reg_wdata;
        end
        if (reg_wr && reg_addr == SVI_ADDR_ENA_TWO) begin
            nxt_st.ena[SVI_NUM_SRC-1:SVI_PEND_ONE_W] =
                reg_wdata[SVI_PEND_TWO_W-1:0];
        end
        if (reg_wr && reg_addr == SVI_ADDR_MASK) begin
            nxt_st.mask = reg_wdata[1:0];
        end

        // A new event beats a clear in the same cycle; acknowledge does
        // not touch the pending bits.
        nxt_st.pend = (st_ff.pend & ~clr_mask) | src_event;

        // ************************************************************
        // Entry and return sequencer
        // ************************************************************
        case (st_ff.state)
            SVI_IDLE: begin
                if (instr_end && interrupt_return_instr) begin
                    nxt_st.mem.req  = 1'b1;
                    nxt_st.mem.addr = {8'h00, cpu_sp};
                    nxt_st.state    = SVI_POP_FLG;
                end else if (instr_end && irq_req &&
                             st_ff.sys_mode[SVI_GIE_BIT]) begin
                    nxt_st.ack   = 1'b1;
                    nxt_st.state = SVI_CLR_GIE;
                end
            end
            SVI_CLR_GIE: begin
                nxt_st.sys_mode[SVI_GIE_BIT] = 1'b0;
                nxt_st.mem.req   = 1'b1;
                nxt_st.mem.we    = 1'b1;
                nxt_st.mem.addr  = {8'h00, cpu_sp - SVI_SP_STEP};
                nxt_st.mem.wdata = cpu_pc[7:0];
                nxt_st.state     = SVI_PUSH_PCL;
            end
            SVI_PUSH_PCL: begin
                nxt_st.mem.req   = 1'b1;
                nxt_st.mem.we    = 1'b1;
                nxt_st.mem.addr  = {8'h00, cpu_sp - 8'h02};
                nxt_st.mem.wdata = cpu_pc[15:8];
                nxt_st.state     = SVI_PUSH_PCH;
            end
            SVI_PUSH_PCH: begin
                nxt_st.mem.req   = 1'b1;
                nxt_st.mem.we    = 1'b1;
                nxt_st.mem.addr  = {8'h00, cpu_sp - SVI_SP_FRAME};
                nxt_st.mem.wdata = cpu_flags;
                nxt_st.state     = SVI_PUSH_FLG;
            end
            SVI_PUSH_FLG: begin
                nxt_st.mem.req  = 1'b1;
                nxt_st.mem.prog = 1'b1;
                nxt_st.mem.addr = SVI_VEC_HI_ADDR;
                nxt_st.state    = SVI_VEC_HI;
            end
            SVI_VEC_HI: begin
                nxt_st.mem.req  = 1'b1;
                nxt_st.mem.prog = 1'b1;
                nxt_st.mem.addr = SVI_VEC_LO_ADDR;
                nxt_st.state    = SVI_VEC_LO;
            end
            SVI_VEC_LO: begin
                nxt_st.hold  = mem_rdata;
                nxt_st.state = SVI_BRANCH;
            end
            SVI_BRANCH: begin
                nxt_st.load.pc_load = 1'b1;
                nxt_st.load.pc      = {st_ff.hold, mem_rdata};
                nxt_st.load.sp_load = 1'b1;
                nxt_st.load.sp      = cpu_sp - SVI_SP_FRAME;
                stat_set[SVI_STAT_ENTRY] = 1'b1;
                nxt_st.state        = SVI_IDLE;
            end
            SVI_POP_FLG: begin
                nxt_st.mem.req  = 1'b1;
                nxt_st.mem.addr = {8'h00, cpu_sp + SVI_SP_STEP};
                nxt_st.state    = SVI_POP_PCH;
            end
            SVI_POP_PCH: begin
                nxt_st.hold2    = mem_rdata;
                nxt_st.mem.req  = 1'b1;
                nxt_st.mem.addr = {8'h00, cpu_sp + 8'h02};
                nxt_st.state    = SVI_POP_PCL;
            end
            SVI_POP_PCL: begin
                nxt_st.hold  = mem_rdata;
                nxt_st.state = SVI_RETURN;
            end
            SVI_RETURN: begin
                nxt_st.load.pc_load    = 1'b1;
                nxt_st.load.pc         = {st_ff.hold, mem_rdata};
                nxt_st.load.flags_load = 1'b1;
                nxt_st.load.flags      = st_ff.hold2;
                nxt_st.load.sp_load    = 1'b1;
                nxt_st.load.sp         = cpu_sp + SVI_SP_FRAME;
                nxt_st.sys_mode[SVI_GIE_BIT] = 1'b1;
                stat_set[SVI_STAT_RETURN] = 1'b1;
                nxt_st.state           = SVI_IDLE;
            end
            default: begin
                nxt_st.state = SVI_IDLE;
            end
        endcase

        // ************************************************************
        // Event status, write one to clear, set wins
        // ************************************************************
        if (reg_wr && reg_addr == SVI_ADDR_STATUS) begin
            nxt_st.stat = st_ff.stat & ~reg_wdata[1:0];
        end
        nxt_st.stat = nxt_st.stat | stat_set;

        // ************************************************************
        // Register reads, data valid in the following cycle
        // ************************************************************
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                SVI_ADDR_SYS_MODE: nxt_st.rdata = st_ff.sys_mode;
                SVI_ADDR_PEND_ONE: nxt_st.rdata = st_ff.pend[7:0];
                SVI_ADDR_PEND_TWO: nxt_st.rdata = {2'h0, st_ff.pend[13:8]};
                SVI_ADDR_ENA_ONE:  nxt_st.rdata = st_ff.ena[7:0];
                SVI_ADDR_ENA_TWO:  nxt_st.rdata = {2'h0, st_ff.ena[13:8]};
                SVI_ADDR_STATUS:   nxt_st.rdata = {6'h00, st_ff.stat};
                SVI_ADDR_MASK:     nxt_st.rdata = {6'h00, st_ff.mask};
                default:           nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff          <= '0;
            st_ff.state    <= SVI_IDLE;
            st_ff.sys_mode <= SVI_SYS_MODE_RST;
            st_ff.pend     <= SVI_SRC_RST;
            st_ff.ena      <= SVI_SRC_RST;
            st_ff.stat     <= SVI_STAT_RST;
            st_ff.mask     <= SVI_STAT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata     = st_ff.rdata;
    assign cpu_ack       = st_ff.ack;
    assign busy          = (st_ff.state != SVI_IDLE);
    assign cpu_load      = st_ff.load;
    assign global_enable = st_ff.sys_mode[SVI_GIE_BIT];
    assign mem           = st_ff.mem;
    assign irq           = |(st_ff.stat & st_ff.mask);

endmodule

//--- rtl/svi_pkg.sv
// Package of the single-vector interrupt entry block: register offsets,
// field positions, reset values, source numbering, states and carriers.
// Assumes one 100 MHz clock and an 8-bit register file address space.
package svi_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] SVI_ADDR_SYS_MODE = 8'hdf;
    localparam logic [7:0] SVI_ADDR_PEND_ONE = 8'hd0;
    localparam logic [7:0] SVI_ADDR_PEND_TWO = 8'hd1;
    localparam logic [7:0] SVI_ADDR_ENA_ONE  = 8'hd2;
    localparam logic [7:0] SVI_ADDR_ENA_TWO  = 8'hd3;
    localparam logic [7:0] SVI_ADDR_STATUS   = 8'hd4;
    localparam logic [7:0] SVI_ADDR_MASK     = 8'hd5;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int         SVI_GIE_BIT       = 3;
    localparam logic [7:0] SVI_SYS_MODE_RST  = 8'h00;
    localparam int         SVI_NUM_SRC       = 14;
    localparam int         SVI_PEND_ONE_W    = 8;
    localparam int         SVI_PEND_TWO_W    = 6;
    localparam logic [13:0] SVI_SRC_RST      = 14'h0000;
    localparam logic [1:0] SVI_STAT_RST      = 2'h0;
    localparam int         SVI_STAT_ENTRY    = 0;
    localparam int         SVI_STAT_RETURN   = 1;

    // Source numbering; bits 0 to 7 are pending register one, bits 8 to
    // 13 are pending register two (watch timer lands on its bit 3).
    localparam int SVI_SRC_P0_BASE = 0;
    localparam int SVI_SRC_P1_BASE = 4;
    localparam int SVI_SRC_TIMER1A = 8;
    localparam int SVI_SRC_TIMERB  = 9;
    localparam int SVI_SRC_SERIAL  = 10;
    localparam int SVI_SRC_WATCH   = 11;
    localparam int SVI_SRC_P3_BASE = 12;

    // ****************************************************************
    // Vector and stack
    // ****************************************************************
    localparam logic [15:0] SVI_VEC_HI_ADDR = 16'h0000;
    localparam logic [15:0] SVI_VEC_LO_ADDR = 16'h0001;
    localparam logic [7:0]  SVI_SP_STEP     = 8'h01;
    localparam logic [7:0]  SVI_SP_FRAME    = 8'h03;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        SVI_IDLE     = 4'b0000,
        SVI_CLR_GIE  = 4'b0001,
        SVI_PUSH_PCL = 4'b0010,
        SVI_PUSH_PCH = 4'b0011,
        SVI_PUSH_FLG = 4'b0100,
        SVI_VEC_HI   = 4'b0101,
        SVI_VEC_LO   = 4'b0110,
        SVI_BRANCH   = 4'b0111,
        SVI_POP_FLG  = 4'b1000,
        SVI_POP_PCH  = 4'b1001,
        SVI_POP_PCL  = 4'b1010,
        SVI_RETURN   = 4'b1011
    } svi_state_e_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        prog;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } svi_mem_t;

    typedef struct packed {
        logic        pc_load;
        logic [15:0] pc;
        logic        flags_load;
        logic [7:0]  flags;
        logic        sp_load;
        logic [7:0]  sp;
    } svi_load_t;

    typedef struct packed {
        svi_state_e_t          state;
        logic [7:0]            sys_mode;
        logic [SVI_NUM_SRC-1:0] pend;
        logic [SVI_NUM_SRC-1:0] ena;
        logic [1:0]            stat;
        logic [1:0]            mask;
        logic [7:0]            rdata;
        logic                  ack;
        logic [7:0]            hold;
        logic [7:0]            hold2;
        svi_mem_t              mem;
        svi_load_t             load;
    } svi_state_t;

endpackage

//--- verification/svi_entry_sva.sv
// Checker of the interrupt entry block: entry, return and read timing.
// Assumes the core holds pc, flags and sp steady while busy is high.
module svi_entry_sva
    import svi_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register port
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Core side
    input wire logic        instr_end,
    input wire logic        interrupt_return_instr,
    input wire logic [15:0] cpu_pc,
    input wire logic [7:0]  cpu_flags,
    input wire logic        irq_req,
    input wire logic        cpu_ack,
    input wire logic        busy,
    input wire svi_load_t   cpu_load,
    input wire logic        global_enable,
    // Memory port
    input wire svi_mem_t    mem,
    input wire logic [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Assertions
    // ********
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_take_req: assert property (
        instr_end && irq_req && global_enable && !interrupt_return_instr
        && !busy |=> cpu_ack)
        else $error("qualified request not acknowledged");
    chk_ack_instr_end: assert property (
        !instr_end |=> !cpu_ack)
        else $error("ack without instruction end");
    chk_ack_gated: assert property (
        !global_enable |=> !cpu_ack)
        else $error("ack while globally disabled");
    chk_ack_clear_ge: assert property (
        cpu_ack |-> busy ##1 !global_enable)
        else $error("entry did not clear global enable");
    chk_push_order: assert property (
        cpu_ack |=> (mem.req && mem.we && mem.wdata == cpu_pc[7:0])
        ##1 (mem.req && mem.we && mem.wdata == cpu_pc[15:8])
        ##1 (mem.req && mem.we && mem.wdata == cpu_flags))
        else $error("push order wrong");
    chk_vector_fetch: assert property (
        cpu_ack |-> ##4 (mem.req && !mem.we && mem.prog
        && mem.addr == SVI_VEC_HI_ADDR) ##1 (mem.req && !mem.we
        && mem.prog && mem.addr == SVI_VEC_LO_ADDR))
        else $error("vector fetch wrong");
    chk_branch_pc: assert property (
        cpu_ack |-> ##7 (cpu_load.pc_load
        && cpu_load.pc == {$past(mem_rdata, 2), $past(mem_rdata)}))
        else $error("branch address wrong");
    chk_return_load: assert property (
        instr_end && interrupt_return_instr && !busy |-> ##5
        (cpu_load.pc_load && cpu_load.flags_load && global_enable))
        else $error("return did not restore");
    chk_reset_ge: assert property (
        $past(rst) |-> !global_enable && !busy)
        else $error("global enable set after reset");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    cover property (cpu_ack);
    cover property (cpu_load.flags_load);
    cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind svi_entry svi_entry_sva u_sva (
    .clk                    (clk),
    .rst                    (rst),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .instr_end              (instr_end),
    .interrupt_return_instr (interrupt_return_instr),
    .cpu_pc                 (cpu_pc),
    .cpu_flags              (cpu_flags),
    .irq_req                (irq_req),
    .cpu_ack                (cpu_ack),
    .busy                   (busy),
    .cpu_load               (cpu_load),
    .global_enable          (global_enable),
    .mem                    (mem),
    .mem_rdata              (mem_rdata)
);

//--- verification/svi_entry_tb.sv
// Bench of the interrupt entry block; the bench plays the core.
// Assumes the memory model answers reads one cycle after the request.
module svi_entry_tb
    import svi_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [13:0] src_event = 14'h0000;
    logic        instr_end = 1'b0;
    logic        en_instr = 1'b0;
    logic        dis_instr = 1'b0;
    logic        ret_instr = 1'b0;
    logic [15:0] cpu_pc = 16'ha5c3;
    logic [7:0]  cpu_flags = 8'h5a;
    logic [7:0]  cpu_sp = 8'h80;
    logic [7:0]  reg_rdata, mem_rdata;
    logic        irq_req, cpu_ack, busy, global_enable, irq;
    svi_load_t   cpu_load;
    svi_mem_t    mem;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          acks = 0;

    svi_entry dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_event(src_event),
        .instr_end(instr_end), .enable_interrupts_instr(en_instr),
        .disable_interrupts_instr(dis_instr),
        .interrupt_return_instr(ret_instr), .cpu_pc(cpu_pc),
        .cpu_flags(cpu_flags), .cpu_sp(cpu_sp), .irq_req(irq_req),
        .cpu_ack(cpu_ack), .busy(busy), .cpu_load(cpu_load),
        .global_enable(global_enable), .mem(mem),
        .mem_rdata(mem_rdata), .irq(irq));
    svi_mem_model mem_m (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

    always #5 clk = ~clk;

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                      input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask

    task automatic core(input logic ret, input logic en, input logic dis);
        @(posedge clk);
        instr_end <= ~(en | dis);
        ret_instr <= ret;
        en_instr <= en;
        dis_instr <= dis;
        @(posedge clk);
        instr_end <= 1'b0;
        ret_instr <= 1'b0;
        en_instr <= 1'b0;
        dis_instr <= 1'b0;
        #1;
    endtask

    task automatic wait_load();
        int n;
        n = 0;
        while (cpu_load.pc_load !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(cpu_load.pc_load, 1'b1, "load pulse");
    endtask

    task automatic end_sim();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (cpu_ack === 1'b1) begin
            acks++;
        end
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_sim();
        end
    end

    // ********
    // Tests
    // ********
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(SVI_ADDR_SYS_MODE, SVI_SYS_MODE_RST, "mode reset");
        rd(8'h10, 8'h00, "unmapped");
        @(posedge clk);
        src_event <= 14'h3fff;
        @(posedge clk);
        src_event <= 14'h0000;
        rd(SVI_ADDR_PEND_ONE, 8'hff, "pend one");
        rd(SVI_ADDR_PEND_TWO, 8'h3f, "pend two");
        chk(irq_req, 1'b0, "req no enable");
        wr(SVI_ADDR_PEND_ONE, 8'hfb);
        rd(SVI_ADDR_PEND_ONE, 8'hfb, "clear port bit");
        wr(SVI_ADDR_PEND_TWO, 8'hf7);
        rd(SVI_ADDR_PEND_TWO, 8'h37, "clear watch");
        wr(SVI_ADDR_ENA_TWO, 8'hff);
        rd(SVI_ADDR_ENA_TWO, 8'h3f, "ena two");
        chk(irq_req, 1'b1, "req source two");
        wr(SVI_ADDR_ENA_TWO, 8'h00);
        wr(SVI_ADDR_ENA_ONE, 8'h01);
        chk(irq_req, 1'b1, "req enabled");
        core(1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        chk(16'(acks), 16'h0000, "ack while disabled");
        wr(SVI_ADDR_SYS_MODE, 8'h08);
        rd(SVI_ADDR_SYS_MODE, 8'h08, "mode write");
        chk(global_enable, 1'b1, "ge by write");
        core(1'b0, 1'b0, 1'b1);
        chk(global_enable, 1'b0, "ge by disable");
        core(1'b0, 1'b1, 1'b0);
        chk(global_enable, 1'b1, "ge by enable");
        repeat (4) @(posedge clk);
        chk(16'(acks), 16'h0000, "ack mid instruction");
        core(1'b0, 1'b0, 1'b0);
        wait_load();
        chk(16'(acks), 16'h0001, "entry ack");
        chk(cpu_load.pc, 16'h3c5e, "vector pc");
        chk(cpu_load.sp, 8'h7d, "sp after push");
        chk(global_enable, 1'b0, "ge cleared");
        chk(mem_m.ram[8'h7f], 8'hc3, "push pc low");
        chk(mem_m.ram[8'h7e], 8'ha5, "push pc high");
        chk(mem_m.ram[8'h7d], 8'h5a, "push flags");
        @(posedge clk);
        cpu_sp <= 8'h7d;
        cpu_pc <= 16'h3c5e;
        cpu_flags <= 8'h00;
        rd(SVI_ADDR_PEND_ONE, 8'hfb, "pend kept");
        chk(irq, 1'b0, "irq masked");
        wr(SVI_ADDR_MASK, 8'h01);
        chk(irq, 1'b1, "irq raised");
        wr(SVI_ADDR_STATUS, 8'h01);
        chk(irq, 1'b0, "irq cleared");
        core(1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        chk(16'(acks), 16'h0001, "no nested entry");
        wr(SVI_ADDR_PEND_ONE, 8'hfa);
        core(1'b1, 1'b0, 1'b0);
        wait_load();
        chk(cpu_load.pc, 16'ha5c3, "pc restored");
        chk(cpu_load.flags, 8'h5a, "flags restored");
        chk(cpu_load.sp, 8'h80, "sp after pop");
        chk(global_enable, 1'b1, "ge restored");
        rd(SVI_ADDR_STATUS, 8'h02, "return status");
        chk(irq_req, 1'b0, "req after clear");
        end_sim();
    end
endmodule

//--- verification/svi_mem_model.sv
// Memory model holding the stack bytes and the two vector bytes.
// Assumes reads are answered one cycle after the request.
module svi_mem_model
    import svi_pkg::*;
#(
    parameter logic [7:0] VEC_HI = 8'h3c,
    parameter logic [7:0] VEC_LO = 8'h5e
)
(
    input  wire logic     clk,
    input  wire svi_mem_t mem,
    output logic [7:0]    mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] ram [256] = '{default: 8'h00};
    logic [7:0] rdata_ff  = 8'h00;

    assign mem_rdata = rdata_ff;

    always @(posedge clk) begin
        if (mem.req && mem.we) begin
            ram[mem.addr[7:0]] <= mem.wdata;
        end
        if (mem.req && !mem.we && mem.prog) begin
            // One shared vector in the first two program bytes.
            rdata_ff <= (mem.addr == SVI_VEC_HI_ADDR) ? VEC_HI
                                                      : VEC_LO;
        end else if (mem.req && !mem.we) begin
            rdata_ff <= ram[mem.addr[7:0]];
        end else begin
            // Between answers the last byte is inverted every cycle, so it is back on the bus every other cycle.
            rdata_ff <= ~rdata_ff;
        end
    end
endmodule
